// ---- hdl/cps_pkg.sv ----
// Constants, types and rule summary for the compressor protection supervisor
// Contract
// - Current in limit band blocks raises; in reduce band keep lowering to minimum.
// - Trip current stops compressor; restart at or below reduce level after 3 min.
// - Six overcurrent trips latch until on/off key; long run clears the count.
// - Failed start stops compressor; retry after 20 s if no fault present.
// - Three failed starts flag start failure and wait 3 min before next group.
// - Five failed groups latch until on/off key; 2 min run clears counts.
// - Loss of synchronism is watched from start and stops compressor at once.
// - Restart 3 min after synchronism stop; six in a row latch until key.
// - Synchronism stop count clears once compressor has run over 10 min.
// - Bus overvoltage after pre-charge stops all; clears below recovery after 3 min.
// - Bus undervoltage stops all; clears above recovery after 3 min stopped.
// - Overvoltage at power application opens relay; fault holds until power cycle.
// - Heating coil below ambient minus difference is valve fault; 3 min; three latch.
// - Valve check off in test and defrost; off or mode change clears it.
// - Power-factor stage protection watched once started; stops stage and compressor.
// - Stage fault recovers after 3 min; three latch; 10 min stage run clears.
// - Outdoor ambient sensor always checked; coil sensor skipped first 10 min heating.
// - Discharge and module-open checked after 3 min run; module short at once.
// - Confirmed short acts as overheat stop plus sensor fault; open reports only.
// - Chassis heater on at or below 32 F, off above 35.6 F, else hold.
// - At 23 F or below stop compressor, heater on; off above 28.4 F.
package cps_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 25000000;
   localparam int SEC_W = 12;
   typedef logic [SEC_W-1:0] cps_sec_t;
   localparam int RESTART_MIN = 3;
   localparam int START_RETRY_S = 20;
   localparam int START_CLR_MIN = 2;
   localparam int LOS_CLR_MIN = 10;
   localparam int PFC_CLR_MIN = 10;
   localparam int COIL_SKIP_MIN = 10;
   localparam int SENS_RUN_MIN = 3;
   localparam int SENS_CONF_S = 30;
   localparam cps_sec_t RESTART_SEC = cps_sec_t'(RESTART_MIN * 60);
   localparam cps_sec_t START_RETRY_SEC = cps_sec_t'(START_RETRY_S);
   localparam cps_sec_t START_CLR_SEC = cps_sec_t'(START_CLR_MIN * 60);
   localparam cps_sec_t LOS_CLR_SEC = cps_sec_t'(LOS_CLR_MIN * 60);
   localparam cps_sec_t PFC_CLR_SEC = cps_sec_t'(PFC_CLR_MIN * 60);
   localparam cps_sec_t COIL_SKIP_SEC = cps_sec_t'(COIL_SKIP_MIN * 60);
   localparam cps_sec_t SENS_RUN_SEC = cps_sec_t'(SENS_RUN_MIN * 60);
   localparam logic [4:0] SENS_CONF_SEC = 5'(SENS_CONF_S);
   // ****************************************
   // Counts and indexes
   // ****************************************
   localparam int NPROT = 4;
   localparam int P_OC = 0;
   localparam int P_LOS = 1;
   localparam int P_RV = 2;
   localparam int P_PFC = 3;
   localparam logic [2:0] OC_LIMIT = 3'h6;
   localparam logic [2:0] LOS_LIMIT = 3'h6;
   localparam logic [2:0] RV_LIMIT = 3'h3;
   localparam logic [2:0] PFC_LIMIT = 3'h3;
   localparam logic [1:0] START_TRIES = 2'h3;
   localparam logic [2:0] START_ROUNDS = 3'h5;
   localparam int NSENS = 4;
   localparam int S_AMB = 0;
   localparam int S_COIL = 1;
   localparam int S_EXH = 2;
   localparam int S_MOD = 3;
   // ****************************************
   // Temperatures, tenths of deg F, signed
   // ****************************************
   typedef logic signed [11:0] cps_temp_t;
   localparam cps_temp_t CHASSIS_ON_T = 12'sh140;
   localparam cps_temp_t CHASSIS_OFF_T = 12'sh164;
   localparam cps_temp_t COMPH_ON_T = 12'sh0e6;
   localparam cps_temp_t COMPH_OFF_T = 12'sh11c;
   // ****************************************
   // Register port
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_CNT = 4'h2;
   localparam int CTRL_CHAS_EN = 0;
   localparam int CTRL_COMPH_EN = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;
   typedef struct packed {
      logic busFlt;
      logic ovFlt;
      logic uvFlt;
      logic ocFlt;
      logic losFlt;
      logic pfcFlt;
      logic rvFlt;
      logic startFlt;
      logic coldStop;
      logic sensOver;
      logic anyLock;
   } cps_prot_s;
endpackage : cps_pkg

// ---- hdl/cps_sec_tick.sv ----
// One-second tick prescaler from the system clock
`timescale 1ns/1ps
module cps_sec_tick #(
   parameter int CYC_PER_SEC = cps_pkg::CLK_HZ
) (
   input wire logic ref_clk,
   input wire logic rstN,
   output logic tick
);
   import cps_pkg::*;
   localparam int CW = $clog2(CYC_PER_SEC);

   generate
      if (CYC_PER_SEC < 2) begin : g_bad
         $error("CYC_PER_SEC must be at least 2");
      end
   endgenerate

   logic [CW-1:0] cnt_r;
   logic tick_r;
   wire wrap = (cnt_r == CW'(CYC_PER_SEC - 1));

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= wrap ? '0 : cnt_r + 1'b1;
         tick_r <= wrap;
      end
   end

   assign tick = tick_r;
endmodule : cps_sec_tick

// ---- hdl/cps_supervisor.sv ----
// Compressor protection supervisor: trips, restart timing, trip counts, heaters
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module cps_supervisor #(
   parameter int CYC_PER_SEC = cps_pkg::CLK_HZ,
   parameter logic [11:0] I_LIMIT = 12'h500,
   parameter logic [11:0] I_REDUCE = 12'h600,
   parameter logic [11:0] I_TRIP = 12'h700,
   parameter logic [11:0] V_OV_TRIP = 12'he00,
   parameter logic [11:0] V_OV_REC = 12'hd00,
   parameter logic [11:0] V_UV_TRIP = 12'h400,
   parameter logic [11:0] V_UV_REC = 12'h500,
   parameter logic [11:0] V_PWRUP_OV = 12'he80,
   parameter logic signed [11:0] RV_DIFF = 12'sh032,
   parameter cps_pkg::cps_sec_t OC_CLR_SEC = cps_pkg::cps_sec_t'(600)
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [11:0] phaseCur,
   input wire logic [11:0] dcBus,
   input wire cps_pkg::cps_temp_t outAmb,
   input wire cps_pkg::cps_temp_t inCoil,
   input wire cps_pkg::cps_temp_t inAmb,
   input wire logic atMinFreq,
   input wire logic compRunning,
   input wire logic pfcRunning,
   input wire logic preChargeDone,
   input wire logic startFail,
   input wire logic outOfStep,
   input wire logic pfcProt,
   input wire logic heatMode,
   input wire logic testMode,
   input wire logic defrost,
   input wire logic turnOff,
   input wire logic modeToFanCoolDry,
   input wire logic onOffKey,
   input wire logic [cps_pkg::NSENS-1:0] sensShort,
   input wire logic [cps_pkg::NSENS-1:0] sensOpen,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   output logic freqHoldUp,
   output logic freqDown,
   output logic compStop,
   output logic pfcDisable,
   output logic relayOpen,
   output logic chassisHeat,
   output logic compHeat,
   output cps_pkg::cps_prot_s protStatus,
   output logic [cps_pkg::NSENS-1:0] sensFault
);
   import cps_pkg::*;

   generate
      if (I_LIMIT > I_REDUCE || I_REDUCE > I_TRIP || V_UV_TRIP >= V_OV_TRIP) begin : g_bad
         $error("Threshold parameters out of order");
      end
   endgenerate

   function automatic cps_sec_t secInc(input cps_sec_t v);
      secInc = (&v) ? v : v + 1'b1;
   endfunction : secInc

   // ****************************************
   // Reset release and second tick
   // ****************************************
   logic [1:0] rstSync_r;
   logic rstN;
   logic tick;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstN = rstSync_r[1];

   cps_sec_tick #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick (
      .ref_clk(ref_clk),
      .rstN(rstN),
      .tick(tick)
   );

   // ****************************************
   // Run and stop timers, seconds
   // ****************************************
   cps_sec_t stopSec_r;
   cps_sec_t runSec_r;
   cps_sec_t pfcRunSec_r;

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         stopSec_r <= '0;
         runSec_r <= '0;
         pfcRunSec_r <= '0;
      end else begin
         stopSec_r <= compRunning ? '0 : (tick ? secInc(stopSec_r) : stopSec_r);
         runSec_r <= !compRunning ? '0 : (tick ? secInc(runSec_r) : runSec_r);
         pfcRunSec_r <= !pfcRunning ? '0 : (tick ? secInc(pfcRunSec_r) : pfcRunSec_r);
      end
   end

   wire stop3 = (stopSec_r >= RESTART_SEC);

   // ****************************************
   // Counted protections: current, sync, valve, stage
   // ****************************************
   logic [NPROT-1:0] trip;
   logic [NPROT-1:0] okClr;
   logic [NPROT-1:0] cntClr;
   logic [NPROT-1:0] modeClr;
   logic [2:0] limit [NPROT];
   logic [NPROT-1:0] flt_r;
   logic [NPROT-1:0] lock_r;
   logic [2:0] cnt_r [NPROT];

   wire cps_temp_t rvLimit = inCoil + RV_DIFF;
   // Trip at or above the trip current
   assign trip[P_OC] = compRunning && (phaseCur >= I_TRIP);
   assign trip[P_LOS] = compRunning && outOfStep;
   // Coil colder than ambient minus difference
   // Check suppressed in test and defrost
   assign trip[P_RV] = heatMode && compRunning && !testMode && !defrost && (rvLimit < inAmb);
   assign trip[P_PFC] = pfcRunning && pfcProt;
   // Restart needs reduce level and 3 min
   assign okClr[P_OC] = (phaseCur <= I_REDUCE) && stop3;
   assign okClr[P_LOS] = stop3;
   assign okClr[P_RV] = stop3;
   assign okClr[P_PFC] = stop3;
   assign cntClr[P_OC] = (runSec_r > OC_CLR_SEC);
   // Over 10 min run clears count
   assign cntClr[P_LOS] = (runSec_r > LOS_CLR_SEC);
   assign cntClr[P_RV] = 1'b0;
   assign cntClr[P_PFC] = (pfcRunSec_r >= PFC_CLR_SEC);
   // Off or mode change clears valve fault
   assign modeClr = {1'b0, turnOff | modeToFanCoolDry, 2'b00};
   assign limit[P_OC] = OC_LIMIT;
   assign limit[P_LOS] = LOS_LIMIT;
   assign limit[P_RV] = RV_LIMIT;
   assign limit[P_PFC] = PFC_LIMIT;

   // A new trip wins over any clear arriving in the same cycle
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         flt_r <= '0;
         lock_r <= '0;
         for (int i = 0; i < NPROT; i++) begin
            cnt_r[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < NPROT; i++) begin
            if (trip[i] && !flt_r[i]) begin
               flt_r[i] <= 1'b1;
               cnt_r[i] <= cnt_r[i] + 1'b1;
               if (cnt_r[i] + 1'b1 >= limit[i]) begin
                  lock_r[i] <= 1'b1;
               end
            end else if (modeClr[i] && !lock_r[i]) begin
               flt_r[i] <= 1'b0;
               cnt_r[i] <= 3'h0;
            end else begin
               if (flt_r[i] && okClr[i] && !lock_r[i]) begin
                  flt_r[i] <= 1'b0;
               end
               if (onOffKey) begin
                  lock_r[i] <= 1'b0;
                  cnt_r[i] <= 3'h0;
               end else if (cntClr[i] && !lock_r[i]) begin
                  cnt_r[i] <= 3'h0;
               end
            end
         end
      end
   end

   // ****************************************
   // DC bus protections
   // ****************************************
   logic ovFlt_r;
   logic uvFlt_r;
   logic busFlt_r;
   logic pwrChk_r;

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         ovFlt_r <= 1'b0;
         uvFlt_r <= 1'b0;
         busFlt_r <= 1'b0;
         pwrChk_r <= 1'b1;
      end else begin
         pwrChk_r <= 1'b0;
         // Power-up overvoltage holds until power cycle
         if (pwrChk_r && dcBus > V_PWRUP_OV) begin
            busFlt_r <= 1'b1;
         end
         if (preChargeDone && dcBus > V_OV_TRIP) begin
            ovFlt_r <= 1'b1;
         end else if (dcBus < V_OV_REC && stop3) begin
            ovFlt_r <= 1'b0;
         end
         if (preChargeDone && dcBus < V_UV_TRIP) begin
            uvFlt_r <= 1'b1;
         end else if (dcBus > V_UV_REC && stop3) begin
            uvFlt_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // Sensor checks
   // ****************************************
   logic [NSENS-1:0] shortEn;
   logic [NSENS-1:0] openEn;
   logic [NSENS-1:0] rawFlt;
   logic [NSENS-1:0] confShort_r;
   logic [NSENS-1:0] confFlt_r;
   logic [4:0] confSec_r [NSENS];

   wire runLong = compRunning && (runSec_r >= SENS_RUN_SEC);
   // Coil sensor skipped early in heating
   wire coilSkip = heatMode && compRunning && (runSec_r < COIL_SKIP_SEC) && !defrost;
   assign shortEn[S_AMB] = 1'b1;
   assign openEn[S_AMB] = 1'b1;
   assign shortEn[S_COIL] = testMode || !coilSkip;
   assign openEn[S_COIL] = testMode || !coilSkip;
   assign shortEn[S_EXH] = testMode || runLong;
   assign openEn[S_EXH] = testMode || runLong;
   // Module short at once, open after run
   assign shortEn[S_MOD] = 1'b1;
   assign openEn[S_MOD] = testMode || runLong;
   assign rawFlt = (sensShort & shortEn) | (sensOpen & openEn);

   // A fault must persist for the confirm time before it acts
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         confShort_r <= '0;
         confFlt_r <= '0;
         for (int s = 0; s < NSENS; s++) begin
            confSec_r[s] <= 5'h0;
         end
      end else begin
         for (int s = 0; s < NSENS; s++) begin
            if (!rawFlt[s]) begin
               confSec_r[s] <= 5'h0;
               confFlt_r[s] <= 1'b0;
               confShort_r[s] <= 1'b0;
            end else if (confSec_r[s] >= SENS_CONF_SEC) begin
               confFlt_r[s] <= 1'b1;
               confShort_r[s] <= sensShort[s] && shortEn[s];
            end else if (tick) begin
               confSec_r[s] <= confSec_r[s] + 1'b1;
            end
         end
      end
   end

   // ****************************************
   // Start failure and heaters
   // ****************************************
   logic [1:0] startTry_r;
   logic [2:0] startRnd_r;
   logic startHold_r;
   logic startLong_r;
   logic startFlt_r;
   logic startLock_r;
   logic chassis_r;
   logic compHeat_r;
   logic [1:0] ctrl_r;
   logic compStop_r;
   logic pfcDis_r;
   logic holdUp_r;
   logic down_r;

   wire otherFlt = (|flt_r) | ovFlt_r | uvFlt_r | busFlt_r | (|confShort_r) | compHeat_r;
   // Long wait after a failed group
   wire cps_sec_t startWait = startLong_r ? RESTART_SEC : START_RETRY_SEC;
   wire startLast = (startTry_r + 1'b1 == START_TRIES);

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         startTry_r <= 2'h0;
         startRnd_r <= 3'h0;
         startHold_r <= 1'b0;
         startLong_r <= 1'b0;
         startFlt_r <= 1'b0;
         startLock_r <= 1'b0;
      end else if (startFail) begin
         startHold_r <= 1'b1;
         startTry_r <= startLast ? 2'h0 : startTry_r + 1'b1;
         startLong_r <= startLast;
         if (startLast) begin
            startFlt_r <= 1'b1;
            startRnd_r <= startRnd_r + 1'b1;
            if (startRnd_r + 1'b1 >= START_ROUNDS) begin
               startLock_r <= 1'b1;
            end
         end
      end else if (onOffKey) begin
         startLock_r <= 1'b0;
         startTry_r <= 2'h0;
         startRnd_r <= 3'h0;
      end else begin
         // Retry only with no fault present
         if (startHold_r && !startLock_r && !otherFlt && stopSec_r >= startWait) begin
            startHold_r <= 1'b0;
            startFlt_r <= 1'b0;
         end
         // Two minutes of run clears counts
         if (runSec_r >= START_CLR_SEC && !startLock_r) begin
            startTry_r <= 2'h0;
            startRnd_r <= 3'h0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         chassis_r <= 1'b0;
         compHeat_r <= 1'b0;
      end else begin
         if (outAmb <= CHASSIS_ON_T) begin
            chassis_r <= 1'b1;
         end else if (outAmb > CHASSIS_OFF_T) begin
            chassis_r <= 1'b0;
         end
         if (outAmb <= COMPH_ON_T) begin
            compHeat_r <= 1'b1;
         end else if (outAmb > COMPH_OFF_T) begin
            compHeat_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // Drive outputs
   // ****************************************
   wire anyLock = (|lock_r) | startLock_r;
   wire stopNow = otherFlt | startHold_r | anyLock;
   // Hold in limit band, lower in reduce band
   wire holdBand = (phaseCur >= I_LIMIT) && (phaseCur < I_REDUCE);
   wire downBand = (phaseCur >= I_REDUCE) && (phaseCur < I_TRIP) && !atMinFreq;
   // Bus faults and stage fault stop the stage
   wire pfcOff = ovFlt_r | uvFlt_r | busFlt_r | flt_r[P_PFC];

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         compStop_r <= 1'b1;
         pfcDis_r <= 1'b1;
         holdUp_r <= 1'b0;
         down_r <= 1'b0;
      end else begin
         compStop_r <= stopNow;
         pfcDis_r <= pfcOff;
         holdUp_r <= holdBand;
         down_r <= downBand;
      end
   end

   assign compStop = compStop_r;
   assign pfcDisable = pfcDis_r;
   assign freqHoldUp = holdUp_r;
   assign freqDown = down_r;
   assign relayOpen = busFlt_r;
   assign chassisHeat = chassis_r && ctrl_r[CTRL_CHAS_EN];
   assign compHeat = compHeat_r && ctrl_r[CTRL_COMPH_EN];
   assign sensFault = confFlt_r;
   assign protStatus = '{busFlt: busFlt_r, ovFlt: ovFlt_r, uvFlt: uvFlt_r,
                         ocFlt: flt_r[P_OC], losFlt: flt_r[P_LOS], pfcFlt: flt_r[P_PFC],
                         rvFlt: flt_r[P_RV], startFlt: startFlt_r, coldStop: compHeat_r,
                         sensOver: |confShort_r, anyLock: anyLock};

   // ****************************************
   // Register port
   // ****************************************
   logic [15:0] rdata_r;
   wire [15:0] statWord = {1'b0, sensFault, protStatus};
   wire [15:0] cntWord = {1'b0, startRnd_r, startTry_r, cnt_r[P_PFC][1:0], cnt_r[P_RV][1:0],
                          cnt_r[P_LOS], cnt_r[P_OC]};
   wire [15:0] rdSel = (regAddr == REG_CTRL) ? {14'h0, ctrl_r} :
                       (regAddr == REG_STAT) ? statWord :
                       (regAddr == REG_CNT) ? cntWord : 16'h0;

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_r <= CTRL_RST;
         rdata_r <= 16'h0;
      end else begin
         if (regWr && regAddr == REG_CTRL) begin
            ctrl_r <= regWdata[1:0];
         end
         rdata_r <= regRd ? rdSel : 16'h0;
      end
   end

   assign regRdata = rdata_r;
endmodule : cps_supervisor

// ---- tb/cps_asserts.sv ----
// Port-level checks for the compressor protection supervisor
`timescale 1ns/1ps
module cps_asserts #(
   parameter logic [11:0] I_LIMIT = 12'h500,
   parameter logic [11:0] I_REDUCE = 12'h600,
   parameter logic [11:0] I_TRIP = 12'h700,
   parameter logic [11:0] V_UV_TRIP = 12'h400
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [11:0] phaseCur,
   input wire logic [11:0] dcBus,
   input wire logic atMinFreq,
   input wire logic compRunning,
   input wire logic pfcRunning,
   input wire logic preChargeDone,
   input wire logic outOfStep,
   input wire logic pfcProt,
   input wire logic freqHoldUp,
   input wire logic freqDown,
   input wire logic compStop,
   input wire logic pfcDisable,
   input wire logic relayOpen,
   input wire cps_pkg::cps_prot_s protStatus
);
   import cps_pkg::*;
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   AST_LIMIT: assert property (compRunning && phaseCur >= I_LIMIT
      && phaseCur < I_REDUCE |=> freqHoldUp) else $error("raise not blocked");
   AST_REDUCE: assert property (compRunning && phaseCur >= I_REDUCE
      && phaseCur < I_TRIP && !atMinFreq |=> freqDown) else $error("no lowering");
   AST_OC_TRIP: assert property (compRunning && phaseCur >= I_TRIP
      |=> protStatus.ocFlt) else $error("overcurrent flag missing");
   AST_OC_CLR: assert property ($fell(protStatus.ocFlt)
      |-> $past(phaseCur) <= I_REDUCE && !$past(compRunning)) else $error("early clear");
   AST_STOP: assert property ($rose(protStatus.ocFlt || protStatus.losFlt)
      |=> compStop [*2]) else $error("compressor not stopped");
   AST_LOS: assert property (compRunning && outOfStep
      |=> protStatus.losFlt) else $error("sync loss flag missing");
   AST_UV: assert property (preChargeDone && dcBus < V_UV_TRIP
      |=> protStatus.uvFlt) else $error("undervoltage flag missing");
   AST_BUS_OFF: assert property ($rose(protStatus.uvFlt || protStatus.ovFlt)
      |=> pfcDisable && compStop) else $error("bus fault did not stop");
   AST_PFC: assert property (pfcRunning && pfcProt
      |-> ##2 (pfcDisable && compStop)) else $error("stage fault did not stop");
   AST_RELAY: assert property (!$fell(relayOpen))
      else $error("relay closed again");
endmodule : cps_asserts
bind cps_supervisor cps_asserts #(.I_LIMIT(I_LIMIT), .I_REDUCE(I_REDUCE), .I_TRIP(I_TRIP),
   .V_UV_TRIP(V_UV_TRIP)) cps_asserts_inst (.*);

// ---- tb/cps_drive_model.sv ----
// Behavioural inverter drive answering the supervisor's stop commands
`timescale 1ns/1ps
module cps_drive_model (
   input wire logic ref_clk,
   input wire logic compStop,
   input wire logic pfcDisable,
   input wire logic freqDown,
   output logic compRunning,
   output logic pfcRunning,
   output logic atMinFreq
);
   logic [3:0] freq_r;
   // Run feedback lags one cycle, like a real drive acknowledging
   always_ff @(posedge ref_clk) begin
      compRunning <= !compStop;
      pfcRunning <= !pfcDisable;
      if (compStop)
         freq_r <= 4'h8;
      else if (freqDown && freq_r != 4'h0)
         freq_r <= freq_r - 4'h1;
   end
   assign atMinFreq = (freq_r == 4'h0);
endmodule : cps_drive_model

// ---- tb/cps_supervisor_tb_top.sv ----
// Self-checking bench for the compressor protection supervisor
`timescale 1ns/1ps
module cps_supervisor_tb_top;
   import cps_pkg::*;
   localparam logic [11:0] I_TRIP = 12'h700;
   localparam cps_temp_t TBL [6] = '{12'sh140, 12'sh164, 12'sh165, 12'sh0e6, 12'sh11c, 12'sh11d};
   logic ref_clk = 0, nrst = 0, atMinFreq, compRunning, pfcRunning, chExp = 0, cmExp = 0;
   logic preChargeDone = 1, startFail = 0, outOfStep = 0, pfcProt = 0, heatMode = 0;
   logic testMode = 0, defrost = 0, turnOff = 0, modeToFanCoolDry = 0, onOffKey = 0;
   logic regWr = 0, regRd = 0, freqHoldUp, freqDown, compStop, pfcDisable, relayOpen;
   logic chassisHeat, compHeat;
   logic [11:0] phaseCur = 0, dcBus = 12'h800;
   cps_temp_t outAmb = 12'sh2bc, inCoil = 12'sh2bc, inAmb = 12'sh2bc;
   logic [3:0] sensShort = 0, sensOpen = 0, regAddr = 0, sensFault;
   logic [15:0] regWdata = 0, regRdata, rdv;
   cps_prot_s protStatus;
   logic [31:0] seed = 32'h0001809d;
   int error_cnt = 0, comparisons = 0, cyc = 0;
   cps_supervisor #(.CYC_PER_SEC(2)) cps_supervisor_inst (.*);
   cps_drive_model cps_drive_model_inst (.*);
   always #20 ref_clk = ~ref_clk;
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic hyst(cps_temp_t t, cps_temp_t on, cps_temp_t off, logic prev);
      return (t <= on) ? 1'b1 : (t > off) ? 1'b0 : prev;
   endfunction : hyst
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (e !== g) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cw(int n);
      repeat (n) @(posedge ref_clk);
   endtask : cw
   task automatic rd(logic [3:0] a);
      @(posedge ref_clk);
      regRd <= 1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 0;
      #1 rdv = regRdata;
   endtask : rd
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge ref_clk);
      regWr <= 1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 0;
   endtask : wr
   task tally_and_finish;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 12000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      cw(4);
      nrst <= 1;
      cw(4);
      rd(REG_CTRL);
      chk("ctrl", 16'h0003, rdv);
      rd(4'hf);
      chk("unmapped", 16'h0000, rdv);
      repeat (100) begin
         @(posedge ref_clk);
         phaseCur <= 12'(xs() % 32'h700);
      end
      for (int i = 1; i <= 6; i++) begin
         cw(5);
         phaseCur <= I_TRIP;
         cw(3);
         chk("ocFlt", 16'h1, 16'(protStatus.ocFlt));
         phaseCur <= 12'(xs() % 32'h601);
         cw(340);
         chk("ocHold", 16'h1, 16'(protStatus.ocFlt));
         cw(40);
         chk("ocClr", 16'(i == 6), 16'(protStatus.ocFlt));
      end
      rd(REG_CNT);
      chk("ocCnt", 16'h6, {13'h0, rdv[2:0]});
      @(posedge ref_clk) onOffKey <= 1;
      @(posedge ref_clk) onOffKey <= 0;
      cw(3);
      chk("key", 16'h0, 16'({protStatus.anyLock, protStatus.ocFlt}));
      for (int k = 0; k < 3; k++) begin
         cw(5);
         if (k == 0) outOfStep <= 1;
         else if (k == 1) dcBus <= 12'h300;
         else pfcProt <= 1;
         cw(3);
         outOfStep <= 0;
         dcBus <= 12'h800;
         pfcProt <= 0;
         chk("fault", 16'(3'b100 >> k),
            16'({protStatus.losFlt, protStatus.uvFlt, protStatus.pfcFlt}));
         cw(380);
         chk("recover", 16'h0,
            16'({protStatus.losFlt, protStatus.uvFlt, protStatus.pfcFlt}));
      end
      for (int k = 0; k < 40; k++) begin
         @(posedge ref_clk);
         outAmb <= (k < 6) ? TBL[k] : cps_temp_t'(200 + xs() % 200);
         cw(3);
         chExp = hyst(outAmb, CHASSIS_ON_T, CHASSIS_OFF_T, chExp);
         cmExp = hyst(outAmb, COMPH_ON_T, COMPH_OFF_T, cmExp);
         chk("heat", 16'({chExp, cmExp, cmExp}),
            16'({chassisHeat, compHeat, protStatus.coldStop}));
      end
      outAmb <= 12'sh0e6;
      wr(REG_CTRL, 16'h0000);
      cw(3);
      chk("heatEn", 16'h1, 16'({chassisHeat, compHeat, protStatus.coldStop}));
      wr(REG_CTRL, 16'h0003);
      outAmb <= 12'sh2bc;
      cw(380);
      heatMode <= 1;
      inCoil <= 12'sh258;
      cw(3);
      chk("valve", 16'h1, 16'(protStatus.rvFlt));
      inCoil <= 12'sh2bc;
      turnOff <= 1;
      @(posedge ref_clk) turnOff <= 0;
      cw(3);
      chk("valveClr", 16'h0, 16'(protStatus.rvFlt));
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk) startFail <= 1;
         @(posedge ref_clk) startFail <= 0;
         cw(30);
         chk("retryWait", 16'h1, 16'(compStop));
         cw(20);
         chk("retry", 16'(k == 2), 16'(compStop));
      end
      chk("startFlt", 16'h1, 16'(protStatus.startFlt));
      nrst <= 0;
      phaseCur <= 0;
      dcBus <= 12'hf00;
      cw(4);
      nrst <= 1;
      cw(6);
      dcBus <= 12'h800;
      cw(5);
      chk("relay", 16'h1, 16'(relayOpen));
      sensShort <= 4'h5;
      sensOpen <= 4'h2;
      cw(40);
      chk("sensEarly", 16'h0, 16'({sensFault, protStatus.sensOver}));
      cw(30);
      chk("sens", 16'h7, 16'({sensFault, protStatus.sensOver}));
      tally_and_finish();
   end
endmodule : cps_supervisor_tb_top
